// [inc/ccm_pkg.sv]
// Constants, field layout and mode decode for one capture/compare module.
// Assumes an APB master on pclk and a shared array counter on the same clock.
// Behaviour
// RULE1 - Comparator runs only while comparator enable set
// RULE2 - Rising pin edge captures when rising enable set
// RULE3 - Falling pin edge captures when falling enable set
// RULE4 - Counter equal compare sets flag when match enabled
// RULE5 - Counter equal compare toggles pin when toggle enabled
// RULE6 - Toggle plus pulse-width selects frequency output mode
// RULE7 - Pulse-width alone drives modulated waveform on pin
// RULE8 - Wide select picks 16-bit, else 8-bit waveform
// RULE9 - Flag interrupt request gated by flag interrupt enable
// RULE10 - Wide select lives in mode register top bit
// RULE11 - Capture copies counter and sets flag together
package ccm_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_COMPARE = 8'h04;
   localparam logic [7:0] OFS_CAPTURE = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h10;

   // Mode register fields
   localparam int BIT_WIDE_PULSE = 7;
   localparam int BIT_CMP_EN = 6;
   localparam int BIT_RISE_CAP = 5;
   localparam int BIT_FALL_CAP = 4;
   localparam int BIT_MATCH_EN = 3;
   localparam int BIT_TOGGLE_EN = 2;
   localparam int BIT_PULSE_EN = 1;
   localparam int BIT_FLAG_IE = 0;

   // Status and mask fields
   localparam int ST_FLAG = 0;
   localparam int ST_CAPTURE = 1;
   localparam int ST_MATCH = 2;
   localparam int ST_W = 3;

   // Reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [15:0] COMPARE_RST = 16'h0000;
   localparam logic [15:0] CAPTURE_RST = 16'h0000;
   localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
   localparam logic [ST_W-1:0] MASK_RST = 3'h0;

   // Pin output functions
   typedef enum logic [1:0] {WAVE_OFF, WAVE_TOGGLE, WAVE_PWM, WAVE_FREQ} ccm_wave_type;

   // Output function selected by the mode register
   function automatic ccm_wave_type ccm_wave_sel(input logic [7:0] mode);
      if (mode[BIT_TOGGLE_EN] && mode[BIT_PULSE_EN]) begin
         return WAVE_FREQ; // [RULE6]
      end else if (mode[BIT_PULSE_EN]) begin
         return WAVE_PWM; // [RULE7]
      end else if (mode[BIT_TOGGLE_EN]) begin
         return WAVE_TOGGLE;
      end else begin
         return WAVE_OFF;
      end
   endfunction

endpackage

// [hdl/ccm_edge_sync.sv]
// Two-flop pin synchroniser with rise and fall pulses.
// Assumes an asynchronous pin and a single clock.
`timescale 1ns/1ps
module ccm_edge_sync (
   input wire logic clk, // Clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic pin_i, // Raw pin level
   output logic rise_o, // One-cycle rising edge pulse
   output logic fall_o // One-cycle falling edge pulse
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // Synchroniser chain plus history for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Edges seen only after the second flop
   assign rise_o = sync_q & ~last_q;
   assign fall_o = ~sync_q & last_q;
endmodule // ccm_edge_sync

// [hdl/ccm_wave.sv]
// Waveform generator: pulse-width level and frequency output target.
// Assumes the counter and compare value come from pclk logic.
`timescale 1ns/1ps
module ccm_wave
   import ccm_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire ccm_pkg::ccm_wave_type wave_i, // Selected output function
   input wire logic wide_i, // 16-bit pulse width when high
   input wire logic [15:0] counter_i, // Shared counter value
   input wire logic [15:0] compare_i, // Compare value
   output logic pwm_level_o, // Pulse-width level
   output logic freq_hit_o // One-cycle frequency toggle pulse
);
   logic [7:0] target_q;
   logic freq_eq_q;
   logic freq_eq;

   // Level is high once the counter reaches or exceeds the compare value
   always_comb begin
      if (wide_i) begin
         pwm_level_o = counter_i >= compare_i; // [RULE8]
      end else begin
         pwm_level_o = counter_i[7:0] >= compare_i[7:0]; // [RULE8]
      end
   end

   // Frequency mode: low byte match, next target advanced by high byte
   assign freq_eq = (wave_i == WAVE_FREQ) && (counter_i[7:0] == target_q);
   assign freq_hit_o = freq_eq & ~freq_eq_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         target_q <= 8'h00;
         freq_eq_q <= 1'b0;
      end else begin
         freq_eq_q <= freq_eq;
         if (wave_i != WAVE_FREQ) begin
            target_q <= compare_i[7:0];
         end else if (freq_hit_o) begin
            target_q <= 8'(target_q + compare_i[15:8]); // [RULE6]
         end
      end
   end
endmodule // ccm_wave

// [hdl/ccm_top.sv]
// Capture/compare module with mode control, APB registers and interrupt.
// Assumes the shared counter arrives on pclk; the pin is asynchronous.
`timescale 1ns/1ps
module ccm_top
   import ccm_pkg::*;
(
   input wire logic pclk, // APB clock, also counter clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [15:0] counter_i, // Shared array counter
   input wire logic module_external_pin_i, // Pin level in
   output logic module_external_pin_o, // Pin level out
   output logic module_external_pin_oe, // Pin driven when high
   output logic irq_o // Level interrupt
);
   logic [7:0] mode_q;
   logic [15:0] compare_q;
   logic [15:0] capture_q;
   logic [ST_W-1:0] status_q;
   logic [ST_W-1:0] mask_q;
   logic [ST_W-1:0] status_set;
   logic [ST_W-1:0] status_clr;
   logic eq_q;
   logic cmp_eq;
   logic match_pulse;
   logic rise;
   logic fall;
   logic cap_evt;
   logic pwm_level;
   logic freq_hit;
   logic wr_acc;
   logic setup;
   logic mapped;
   logic flag_req;
   ccm_wave_type wave;

   // Bus phases: writes land at the end of the access cycle
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pready & pwrite;
   assign mapped = (paddr == OFS_MODE) || (paddr == OFS_COMPARE) || (paddr == OFS_CAPTURE)
      || (paddr == OFS_STATUS) || (paddr == OFS_MASK);

   // Pin synchroniser and edge detector
   ccm_edge_sync u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .pin_i(module_external_pin_i),
      .rise_o(rise),
      .fall_o(fall)
   );

   // Output function decode and waveform generator
   assign wave = ccm_wave_sel(mode_q);

   ccm_wave u_wave (
      .clk(pclk),
      .rst_n(presetn),
      .wave_i(wave),
      .wide_i(mode_q[BIT_WIDE_PULSE]), // [RULE10]
      .counter_i(counter_i),
      .compare_i(compare_q),
      .pwm_level_o(pwm_level),
      .freq_hit_o(freq_hit)
   );

   // Comparator, active only when enabled; one pulse per match
   assign cmp_eq = mode_q[BIT_CMP_EN] && (counter_i == compare_q); // [RULE1]
   assign match_pulse = cmp_eq & ~eq_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eq_q <= 1'b0;
      end else begin
         eq_q <= cmp_eq;
      end
   end

   // Capture on enabled pin edges
   assign cap_evt = (rise & mode_q[BIT_RISE_CAP]) // [RULE2]
      | (fall & mode_q[BIT_FALL_CAP]); // [RULE3]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_q <= CAPTURE_RST;
      end else if (cap_evt) begin
         capture_q <= counter_i; // [RULE11]
      end
   end

   // Mode, compare and mask registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= MODE_RST;
         compare_q <= COMPARE_RST;
         mask_q <= MASK_RST;
      end else if (wr_acc) begin
         if (paddr == OFS_MODE) begin
            mode_q <= pwdata[7:0]; // [RULE10]
         end else if (paddr == OFS_COMPARE) begin
            compare_q <= pwdata[15:0];
         end else if (paddr == OFS_MASK) begin
            mask_q <= pwdata[ST_W-1:0];
         end
      end
   end

   // Sticky status, write one to clear, set wins over clear
   always_comb begin
      status_set = '0;
      status_set[ST_FLAG] = cap_evt | (match_pulse & mode_q[BIT_MATCH_EN]); // [RULE4] [RULE11]
      status_set[ST_CAPTURE] = cap_evt;
      status_set[ST_MATCH] = match_pulse;
      status_clr = (wr_acc && paddr == OFS_STATUS) ? pwdata[ST_W-1:0] : '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= STATUS_RST;
      end else begin
         status_q <= (status_q & ~status_clr) | status_set;
      end
   end

   // Interrupt: flag needs its own enable as well as the mask
   assign flag_req = status_q[ST_FLAG] & mode_q[BIT_FLAG_IE] & mask_q[ST_FLAG]; // [RULE9]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= flag_req | (|(status_q[ST_W-1:1] & mask_q[ST_W-1:1]));
      end
   end

   // Pin driver
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         module_external_pin_o <= 1'b0;
         module_external_pin_oe <= 1'b0;
      end else begin
         module_external_pin_oe <= (wave != WAVE_OFF);
         case (wave)
            WAVE_TOGGLE: begin
               if (match_pulse) begin
                  module_external_pin_o <= ~module_external_pin_o; // [RULE5]
               end
            end
            WAVE_FREQ: begin
               if (freq_hit && mode_q[BIT_CMP_EN]) begin
                  module_external_pin_o <= ~module_external_pin_o; // [RULE6]
               end
            end
            WAVE_PWM: begin
               if (mode_q[BIT_CMP_EN]) begin
                  module_external_pin_o <= pwm_level; // [RULE7]
               end
            end
            default: begin
               module_external_pin_o <= module_external_pin_o;
            end
         endcase
      end
   end

   // APB answer prepared in the setup cycle, one access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         if (setup && !pwrite) begin
            if (paddr == OFS_MODE) begin
               prdata <= {24'h00_0000, mode_q};
            end else if (paddr == OFS_COMPARE) begin
               prdata <= {16'h0000, compare_q};
            end else if (paddr == OFS_CAPTURE) begin
               prdata <= {16'h0000, capture_q};
            end else if (paddr == OFS_STATUS) begin
               prdata <= {29'h0000_0000, status_q};
            end else if (paddr == OFS_MASK) begin
               prdata <= {29'h0000_0000, mask_q};
            end else begin
               prdata <= 32'h0000_0000;
            end
         end
      end
   end

   // Checks
   chk_match_needs_cmp: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      $rose(status_q[ST_MATCH]) |-> $past(mode_q[BIT_CMP_EN]))
      else $error("match seen with comparator disabled");

   chk_rise_capture: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
      (rise && mode_q[BIT_RISE_CAP]) |=> (capture_q == $past(counter_i)))
      else $error("rising edge capture missed");

   chk_fall_capture_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
      (fall && mode_q[BIT_FALL_CAP]) |=> (capture_q == $past(counter_i)) && status_q[ST_FLAG])
      else $error("falling edge capture missed");

   chk_no_capture_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
      (!cap_evt) |=> (capture_q == $past(capture_q)))
      else $error("capture changed without edge");

   chk_match_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      (mode_q[BIT_CMP_EN] && mode_q[BIT_MATCH_EN] && counter_i == compare_q && !eq_q)
      |=> status_q[ST_FLAG])
      else $error("match did not set flag");

   chk_toggle_pin: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
      (wave == WAVE_TOGGLE && match_pulse) |=> (module_external_pin_o != $past(module_external_pin_o)))
      else $error("pin did not toggle on match");

   chk_freq_select: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
      (mode_q[BIT_TOGGLE_EN] && mode_q[BIT_PULSE_EN] && mode_q[BIT_CMP_EN] && freq_hit)
      |-> (wave == WAVE_FREQ) ##1 (module_external_pin_o != $past(module_external_pin_o)))
      else $error("frequency mode not toggling");

   chk_pwm_narrow: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7] [RULE8]
      (wave == WAVE_PWM && mode_q[BIT_CMP_EN] && !mode_q[BIT_WIDE_PULSE])
      |=> (module_external_pin_o == ($past(counter_i[7:0]) >= $past(compare_q[7:0]))))
      else $error("8-bit pulse level wrong");

   chk_pwm_wide: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
      (wave == WAVE_PWM && mode_q[BIT_CMP_EN] && mode_q[BIT_WIDE_PULSE])
      |=> (module_external_pin_o == ($past(counter_i) >= $past(compare_q))))
      else $error("16-bit pulse level wrong");

   chk_flag_irq_mask: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
      (status_q[ST_FLAG] && mask_q[ST_FLAG] && mode_q[BIT_FLAG_IE]) |=> irq_o)
      else $error("flag interrupt not raised");

   chk_flag_irq_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
      (!mode_q[BIT_FLAG_IE] && (status_q[ST_W-1:1] & mask_q[ST_W-1:1]) == '0) |=> !irq_o)
      else $error("flag interrupt not masked");

   chk_wide_bit_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
      (wr_acc && paddr == OFS_MODE) |=> (mode_q[BIT_WIDE_PULSE] == $past(pwdata[7])))
      else $error("wide select not in top bit");

   // Capture side: disabled edges leave the register alone; a capture loads it and sets both flags
   chk_rise_off_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
      (rise && !mode_q[BIT_RISE_CAP]) |=> $stable(capture_q))
      else $error("capture on disabled rising edge");

   chk_fall_off_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
      (fall && !mode_q[BIT_FALL_CAP]) |=> $stable(capture_q))
      else $error("capture on disabled falling edge");

   chk_cap_flag_same: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
      cap_evt |=> status_q[ST_FLAG] && status_q[ST_CAPTURE] && (capture_q == $past(counter_i)))
      else $error("capture and flag not in one cycle");

   // Flag and comparator side
   chk_match_off_noflag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      (!mode_q[BIT_MATCH_EN] && !cap_evt) |=> !$rose(status_q[ST_FLAG]))
      else $error("flag set with match disabled");

   chk_cmp_off_pin: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      !mode_q[BIT_CMP_EN] |=> $stable(module_external_pin_o))
      else $error("pin moved with comparator disabled");

   // Pin side: level held between events, driven while a function is on
   chk_toggle_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
      (wave == WAVE_TOGGLE && !match_pulse) |=> $stable(module_external_pin_o))
      else $error("pin toggled without match");

   chk_freq_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
      (wave == WAVE_FREQ && !freq_hit) |=> $stable(module_external_pin_o))
      else $error("frequency pin moved without hit");

   chk_pin_oe_on: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
      (wave != WAVE_OFF) |=> module_external_pin_oe)
      else $error("pin not driven with function on");

   chk_pin_oe_off: assert property (@(posedge pclk) disable iff (!presetn)
      (wave == WAVE_OFF) |=> !module_external_pin_oe)
      else $error("pin driven with function off");

   // Bus side: one access cycle, error only for unmapped offsets
   chk_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready && (pslverr == !$past(mapped)))
      else $error("ready or error wrong after setup");

   chk_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !setup |=> !pready && !pslverr)
      else $error("ready without setup");

   chk_status_w1c: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == OFS_STATUS && !cap_evt && !match_pulse)
      |=> ((status_q & $past(pwdata[ST_W-1:0])) == '0))
      else $error("status bit not cleared by write");

endmodule // ccm_top

// [dv/ccm_pin_model.sv]
// Model of the outside world at the capture/compare pin.
// Assumes the bench sets the level an outside source drives.
`timescale 1ns/1ps
module ccm_pin_model (
   input wire logic src_level, // Level from the outside source
   input wire logic pin_out, // Level the block drives
   input wire logic pin_oe, // Block drives the pin when high
   output logic pin_level // Resolved wire level
);
   // The block wins while it drives; otherwise the source sets the wire
   assign pin_level = pin_oe ? pin_out : src_level;
endmodule // ccm_pin_model

// [dv/ccm_top_test.sv]
// Self-checking bench for the capture/compare block.
// Assumes one 200 MHz clock; the bench is APB master and counter source.
`timescale 1ns/1ps
module ccm_top_test;
   import ccm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext, pin_i, pin_o, pin_oe, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] cnt;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;

   ccm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .counter_i(cnt), .module_external_pin_i(pin_i), .module_external_pin_o(pin_o),
      .module_external_pin_oe(pin_oe), .irq_o(irq));
   ccm_pin_model pin (.src_level(ext), .pin_out(pin_o), .pin_oe(pin_oe), .pin_level(pin_i));

   // Clock generation
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, r, exp);
   endtask

   // Reset values, read/write fields and an unmapped address
   task automatic t_regs();
      logic [31:0] r;
      logic e;
      rchk("mode_rst", OFS_MODE, 32'h0);
      rchk("cmp_rst", OFS_COMPARE, 32'h0);
      rchk("cap_rst", OFS_CAPTURE, 32'h0);
      rchk("stat_rst", OFS_STATUS, 32'h0);
      rchk("mask_rst", OFS_MASK, 32'h0);
      wr(OFS_MODE, 32'hFFFF_FF80);
      rchk("mode_top", OFS_MODE, 32'h80);
      wr(OFS_MODE, 32'h0);
      wr(OFS_COMPARE, 32'hFFFF_ABCD);
      rchk("cmp_rw", OFS_COMPARE, 32'h0000_ABCD);
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk("unmapped_err", {31'h0, e}, 32'h1);
      chk("unmapped_rd", r, 32'h0);
   endtask

   // Edge captures with each enable alone
   task automatic t_capture();
      wr(OFS_MODE, 32'h20);
      cnt <= 16'h1234;
      ext <= 1'b1;
      cyc(8);
      rchk("cap_rise", OFS_CAPTURE, 32'h1234);
      rchk("flag_rise", OFS_STATUS, 32'h3);
      wr(OFS_STATUS, 32'h7);
      cnt <= 16'h5678;
      ext <= 1'b0;
      cyc(8);
      rchk("no_fall_cap", OFS_CAPTURE, 32'h1234);
      wr(OFS_MODE, 32'h10);
      cnt <= 16'h9ABC;
      ext <= 1'b1;
      cyc(8);
      rchk("no_rise_cap", OFS_CAPTURE, 32'h1234);
      ext <= 1'b0;
      cyc(8);
      rchk("cap_fall", OFS_CAPTURE, 32'h9ABC);
      wr(OFS_STATUS, 32'h7);
   endtask

   // Match flag needs the comparator enabled
   task automatic t_match();
      cnt <= 16'h0;
      wr(OFS_COMPARE, 32'h40);
      wr(OFS_MODE, 32'h08);
      cnt <= 16'h0040;
      cyc(4);
      rchk("cmp_off", OFS_STATUS, 32'h0);
      cnt <= 16'h0;
      wr(OFS_MODE, 32'h48);
      cnt <= 16'h0040;
      cyc(4);
      rchk("match_flag", OFS_STATUS, 32'h5);
      wr(OFS_STATUS, 32'h7);
   endtask

   // Pin inverts on each entry into equality
   task automatic t_toggle();
      logic p0;
      cnt <= 16'h0;
      wr(OFS_MODE, 32'h44);
      cyc(3);
      p0 = pin_o;
      chk("tog_oe", {31'h0, pin_oe}, 32'h1);
      cnt <= 16'h0040;
      cyc(4);
      chk("tog_1", {31'h0, pin_o}, {31'h0, ~p0});
      cnt <= 16'h0041;
      cyc(4);
      cnt <= 16'h0040;
      cyc(4);
      chk("tog_2", {31'h0, pin_o}, {31'h0, p0});
      rchk("tog_noflag", OFS_STATUS, 32'h4);
      wr(OFS_MASK, 32'h4);
      cyc(2);
      chk("irq_event", {31'h0, irq}, 32'h1);
      wr(OFS_STATUS, 32'h7);
      wr(OFS_MASK, 32'h0);
   endtask

   // Pulse-width level in 8-bit and 16-bit form
   task automatic t_pwm();
      wr(OFS_COMPARE, 32'h0180);
      cnt <= 16'h0090;
      wr(OFS_MODE, 32'h42);
      cyc(4);
      chk("pwm8", {31'h0, pin_o}, 32'h1);
      wr(OFS_MODE, 32'hC2);
      cyc(4);
      chk("pwm16_lo", {31'h0, pin_o}, 32'h0);
      cnt <= 16'h0190;
      cyc(4);
      chk("pwm16_hi", {31'h0, pin_o}, 32'h1);
   endtask

   // Frequency output toggles at an advancing target
   task automatic t_freq();
      logic p0;
      cnt <= 16'h0;
      wr(OFS_COMPARE, 32'h1010);
      wr(OFS_MODE, 32'h46);
      cyc(3);
      p0 = pin_o;
      cnt <= 16'h0010;
      cyc(4);
      chk("freq_1", {31'h0, pin_o}, {31'h0, ~p0});
      cnt <= 16'h0020;
      cyc(4);
      chk("freq_2", {31'h0, pin_o}, {31'h0, p0});
   endtask

   // Flag interrupt gated by the enable bit, cleared with the flag
   task automatic t_irq();
      wr(OFS_MASK, 32'h1);
      wr(OFS_MODE, 32'h21);
      ext <= 1'b1;
      cyc(8);
      chk("irq_on", {31'h0, irq}, 32'h1);
      wr(OFS_MODE, 32'h20);
      cyc(2);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wr(OFS_MODE, 32'h21);
      cyc(2);
      chk("irq_again", {31'h0, irq}, 32'h1);
      wr(OFS_STATUS, 32'h7);
      cyc(2);
      chk("irq_clear", {31'h0, irq}, 32'h0);
   endtask

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cnt = 16'h0;
      ext = 1'b0;
      cyc(8);
      presetn <= 1'b1;
      t_regs();
      t_capture();
      t_match();
      t_toggle();
      t_pwm();
      t_freq();
      t_irq();
      tally_and_finish();
   end
endmodule // ccm_top_test
